//--- core/tsm_pkg.sv
// Purpose: Shared constants and types of the transformer load state monitor
// Assumes: 200 MHz core clock, currents in 0.1 A steps
// Notes:   Offsets are byte addresses on the plain register port
package tsm_pkg;
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned NOLOAD_TIME_MS = 10;
  localparam int unsigned NOLOAD_CYC     = CLK_HZ / 1000 * NOLOAD_TIME_MS;
  localparam int unsigned TICK_TIME_MS   = 1;
  localparam int unsigned TICK_CYC       = CLK_HZ / 1000 * TICK_TIME_MS;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_POWER  = 8'h08;
  localparam logic [7:0] OFS_HV_V   = 8'h0C;
  localparam logic [7:0] OFS_LV_V   = 8'h10;
  localparam logic [7:0] OFS_ZK     = 8'h14;
  localparam logic [7:0] OFS_FREQ   = 8'h18;
  localparam logic [7:0] OFS_EVSEL  = 8'h1C;
  localparam logic [7:0] OFS_ISTAT  = 8'h20;
  localparam logic [7:0] OFS_IMASK  = 8'h24;
  localparam logic [7:0] OFS_OVL_T  = 8'h28;
  localparam logic [7:0] OFS_HOC_T  = 8'h2C;
  localparam logic [7:0] OFS_INOM_H = 8'h30;
  localparam logic [7:0] OFS_INOM_L = 8'h34;
  localparam logic [7:0] OFS_ISC_H  = 8'h38;
  localparam logic [7:0] OFS_LSC    = 8'h3C;

  // Setting values: power and voltages in 0.1 units, impedance in 0.01 %
  localparam logic [12:0] RST_POWER = 13'h000A;
  localparam logic [12:0] RST_VOLT  = 13'h044C;
  localparam logic [12:0] MAX_SET   = 13'h1388;
  localparam logic [11:0] RST_ZK    = 12'h012C;
  localparam logic [11:0] MAX_ZK    = 12'h09C4;
  localparam logic [6:0]  RST_FREQ  = 7'h32;
  localparam logic [6:0]  MIN_FREQ  = 7'h0A;
  localparam logic [6:0]  MAX_FREQ  = 7'h4B;

  // Per-unit compare: I10 * U10 * sqrt3(Q10) against thr10 * 1024000 * S10
  localparam logic [47:0] SQRT3_Q  = 48'h0000_0000_06EE;
  localparam logic [47:0] PU_SCALE = 48'h0000_000F_A000;
  localparam logic [47:0] THR_LOW  = 48'h0000_0000_0002;
  localparam logic [47:0] THR_NOM  = 48'h0000_0000_000A;
  localparam logic [47:0] THR_HIGH = 48'h0000_0000_000D;
  localparam logic [47:0] ISC_NUM  = 48'h0000_0000_2710;
  localparam logic [63:0] LSC_NUM  = 64'h0000_0000_0000_065E;
  localparam logic [63:0] LSC_DEN  = 64'h0000_0000_0000_0400;

  typedef enum logic [2:0] {
    MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF
  } tsm_mode_e;

  typedef enum logic [2:0] {
    FORCE_NONE, FORCE_NOLOAD, FORCE_HV_INRUSH, FORCE_LV_INRUSH,
    FORCE_NORMAL, FORCE_OVERLOAD, FORCE_HIGH_OVERLOAD
  } tsm_force_e;

  typedef enum logic [2:0] {
    LD_NORMAL, LD_LOW_WAIT, LD_NOLOAD, LD_INRUSH, LD_OVERLOAD, LD_HIGH
  } tsm_load_e;

  typedef struct packed {
    logic high_overload;
    logic overloading;
    logic load_normal;
    logic lv_inrush;
    logic hv_inrush;
    logic no_load;
  } tsm_flags_s;

  typedef struct packed {
    logic [12:0] power;
    logic [12:0] hv_volt;
    logic [12:0] lv_volt;
  } tsm_plate_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tsm_bus_req_s;
endpackage : tsm_pkg

//--- core/tsm_monitor.sv
// Purpose: Transformer load state monitor with register port and interrupt
// Assumes: Phase currents arrive as the largest phase per side, 0.1 A steps
// Notes:
// Notes on behaviour
// (RL1) No-load shows only after the current stayed under 0.2 pu longer than 10 ms.
// (RL2) A rise from no-load to above 1.3 pu raises both HV and LV inrush.
// (RL3) Normal load shows while the current is between the no-load and nominal limits.
// (RL4) Overloading shows while the current is between nominal and heavy overload.
// (RL5) Currents are compared per unit of nominals made from the nameplate data.
// (RL6) Time spent in overloading and in high overcurrent is accumulated.
// (RL7) Events come from the status outputs and only when selected.
// (RL8) The operating mode is On, Blocked, Test, Test/Blocked or Off, default On.
// (RL9) The mode actually in force is readable from the same five values.
// (RL10) With group control on, nameplate values follow one of 8 groups one cycle after setting_group changes; off by default.
// (RL11) The status may be forced to one of seven choices, only with forcing enabled.
// (RL12) Rated power is kept in 0.1 MVA steps, default 1.0 MVA, for both nominals.
// (RL13) HV nominal voltage is kept in 0.1 kV steps, default 110.0 kV.
// (RL14) LV nominal voltage is kept in 0.1 kV steps, default 110.0 kV.
// (RL15) Short-circuit impedance is kept in 0.01 % steps, default 3.00 %.
// (RL16) Nominal frequency is kept in 1 Hz steps, default 50 Hz.
// (RL17) Each nominal current is power over root three times that side's voltage.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tsm_monitor #(
  parameter int unsigned NOLOAD_CYCLES = tsm_pkg::NOLOAD_CYC,
  parameter int unsigned TICK_CYCLES   = tsm_pkg::TICK_CYC,
  parameter int unsigned CUR_W         = 16
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire tsm_pkg::tsm_bus_req_s  bus_req,
  output logic [31:0]                 rd_data,
  input  wire logic [CUR_W-1:0]       hv_current,
  input  wire logic [CUR_W-1:0]       lv_current,
  input  wire logic [2:0]             setting_group,
  output tsm_pkg::tsm_flags_s         status,
  output logic [5:0]                  event_pulse,
  output tsm_pkg::tsm_mode_e          function_effective_mode,
  output logic                        irq
);
  if (NOLOAD_CYCLES < 2 || NOLOAD_CYCLES > 32'h7FFF_FFFF || TICK_CYCLES < 1
      || CUR_W < 4 || CUR_W > 24) begin : g_chk
    $error("tsm_monitor: unsupported parameter value");
  end

  typedef struct packed {
    tsm_pkg::tsm_mode_e          function_operating_mode;
    logic                        sg_ctrl_en;
    logic                        force_en;
    tsm_pkg::tsm_force_e         force_sel;
    logic [2:0]                  wr_group;
    logic [2:0]                  grp_act;
    tsm_pkg::tsm_plate_s [7:0]   plate;
    logic [11:0]                 short_circuit_impedance_pct;
    logic [6:0]                  freq;
    logic [5:0]                  evt_sel;
    logic [5:0]                  int_stat;
    logic [5:0]                  int_mask;
    logic [47:0]                 prod_hv;
    logic [47:0]                 prod_lv;
    tsm_pkg::tsm_load_e          load;
    logic [31:0]                 low_cnt;
    logic [31:0]                 tick_cnt;
    logic [31:0]                 ovl_time;
    logic [31:0]                 hoc_time;
    logic [31:0]                 inom_hv;
    logic [31:0]                 inom_lv;
    logic [31:0]                 isc_hv;
    logic [31:0]                 lsc;
    tsm_pkg::tsm_flags_s         flags;
    logic [5:0]                  evt;
    logic [31:0]                 rdata;
  } tsm_state_s;

  function automatic tsm_state_s rst_state();
    tsm_state_s s;
    s = '0;
    s.function_operating_mode = tsm_pkg::MODE_ON; // RL8
    s.force_sel = tsm_pkg::FORCE_NONE; // RL11
    s.load = tsm_pkg::LD_NORMAL;
    for (int g = 0; g < 8; g++) begin
      s.plate[g].power   = tsm_pkg::RST_POWER; // RL12
      s.plate[g].hv_volt = tsm_pkg::RST_VOLT; // RL13
      s.plate[g].lv_volt = tsm_pkg::RST_VOLT; // RL14
    end
    s.short_circuit_impedance_pct = tsm_pkg::RST_ZK; // RL15
    s.freq = tsm_pkg::RST_FREQ; // RL16
    return s;
  endfunction : rst_state

  function automatic logic [12:0] clamp_set(input logic [31:0] v);
    if (v == 32'h0000_0000) return 13'h0001;
    if (v > 32'(tsm_pkg::MAX_SET)) return tsm_pkg::MAX_SET;
    return v[12:0];
  endfunction : clamp_set

  // Band of one side: 0 no-load, 1 normal, 2 overload, 3 heavy
  function automatic logic [1:0] band(input logic [47:0] p,
                                      input logic [12:0] pw);
    logic [47:0] base;
    base = tsm_pkg::PU_SCALE * 48'(pw);
    if (p < tsm_pkg::THR_LOW * base) return 2'h0; // RL5
    if (p <= tsm_pkg::THR_NOM * base) return 2'h1;
    if (p <= tsm_pkg::THR_HIGH * base) return 2'h2;
    return 2'h3;
  endfunction : band

  function automatic tsm_pkg::tsm_load_e by_band(input logic [1:0] b);
    case (b)
      2'h0: return tsm_pkg::LD_LOW_WAIT;
      2'h1: return tsm_pkg::LD_NORMAL;
      2'h2: return tsm_pkg::LD_OVERLOAD;
      default: return tsm_pkg::LD_HIGH;
    endcase
  endfunction : by_band

  function automatic tsm_pkg::tsm_flags_s flags_of(
      input tsm_pkg::tsm_load_e l);
    tsm_pkg::tsm_flags_s f;
    f = '0;
    case (l)
      tsm_pkg::LD_NOLOAD: f.no_load = 1'b1; // RL1
      tsm_pkg::LD_INRUSH: begin
        f.hv_inrush = 1'b1; // RL2
        f.lv_inrush = 1'b1; // RL2
      end
      tsm_pkg::LD_OVERLOAD: f.overloading = 1'b1; // RL4
      tsm_pkg::LD_HIGH: f.high_overload = 1'b1;
      default: f.load_normal = 1'b1; // RL3
    endcase
    return f;
  endfunction : flags_of

  function automatic tsm_pkg::tsm_flags_s forced(input tsm_pkg::tsm_force_e c);
    tsm_pkg::tsm_flags_s f;
    f = '0;
    case (c)
      tsm_pkg::FORCE_NOLOAD: f.no_load = 1'b1;
      tsm_pkg::FORCE_HV_INRUSH: f.hv_inrush = 1'b1;
      tsm_pkg::FORCE_LV_INRUSH: f.lv_inrush = 1'b1;
      tsm_pkg::FORCE_NORMAL: f.load_normal = 1'b1;
      tsm_pkg::FORCE_OVERLOAD: f.overloading = 1'b1;
      tsm_pkg::FORCE_HIGH_OVERLOAD: f.high_overload = 1'b1;
      default: f = '0;
    endcase
    return f;
  endfunction : forced

  tsm_state_s           st_reg;
  tsm_state_s           st_next;
  tsm_pkg::tsm_plate_s  act;
  tsm_pkg::tsm_mode_e   eff;
  logic [1:0]           b_hv;
  logic [1:0]           b_lv;
  logic [1:0]           b_max;
  logic                 live;
  logic                 frc;
  logic                 tick;
  logic [47:0]          inom_h_w;
  logic [47:0]          inom_l_w;
  logic [63:0]          lsc_w;

  assign act   = st_reg.plate[st_reg.grp_act];
  assign b_hv  = band(st_reg.prod_hv, act.power);
  assign b_lv  = band(st_reg.prod_lv, act.power);
  assign b_max = (b_hv > b_lv) ? b_hv : b_lv;
  assign frc   = st_reg.force_en && st_reg.force_sel != tsm_pkg::FORCE_NONE;
  assign tick  = st_reg.tick_cnt >= 32'(TICK_CYCLES - 1);
  assign eff   = (st_reg.function_operating_mode > tsm_pkg::MODE_OFF)
                 ? tsm_pkg::MODE_OFF : st_reg.function_operating_mode; // RL9
  assign live  = eff == tsm_pkg::MODE_ON || eff == tsm_pkg::MODE_TEST; // RL8

  // Nominal current in amps, short-circuit current, inductance in uH
  assign inom_h_w = (48'(act.power) * tsm_pkg::PU_SCALE)
                    / (tsm_pkg::SQRT3_Q * 48'(act.hv_volt)); // RL17
  assign inom_l_w = (48'(act.power) * tsm_pkg::PU_SCALE)
                    / (tsm_pkg::SQRT3_Q * 48'(act.lv_volt)); // RL17
  assign lsc_w = (64'(st_reg.short_circuit_impedance_pct)
                  * 64'(act.hv_volt) * 64'(act.hv_volt) * tsm_pkg::LSC_NUM)
                 / (tsm_pkg::LSC_DEN * 64'(act.power)
                    * 64'(st_reg.freq)); // RL16

  always_comb begin
    st_next = st_reg;
    st_next.grp_act = st_reg.sg_ctrl_en ? setting_group : 3'h0; // RL10
    st_next.prod_hv = 48'(hv_current) * 48'(act.hv_volt)
                      * tsm_pkg::SQRT3_Q; // RL5
    st_next.prod_lv = 48'(lv_current) * 48'(act.lv_volt)
                      * tsm_pkg::SQRT3_Q; // RL5
    st_next.inom_hv = inom_h_w[31:0]; // RL12
    st_next.inom_lv = inom_l_w[31:0];
    st_next.isc_hv = 32'((inom_h_w * tsm_pkg::ISC_NUM)
                    / 48'(st_reg.short_circuit_impedance_pct)); // RL15
    st_next.lsc = lsc_w[31:0];
    st_next.low_cnt = 32'h0000_0000;
    case (st_reg.load)
      tsm_pkg::LD_LOW_WAIT: begin
        if (b_max != 2'h0) begin
          st_next.load = by_band(b_max);
        end else if (st_reg.low_cnt >= 32'(NOLOAD_CYCLES - 1)) begin
          st_next.load = tsm_pkg::LD_NOLOAD; // RL1
        end else begin
          st_next.low_cnt = st_reg.low_cnt + 32'h0000_0001; // RL1
        end
      end
      tsm_pkg::LD_NOLOAD: begin
        if (b_max == 2'h3) begin
          st_next.load = tsm_pkg::LD_INRUSH; // RL2
        end else if (b_max != 2'h0) begin
          st_next.load = by_band(b_max);
        end
      end
      tsm_pkg::LD_INRUSH: begin
        if (b_max != 2'h3) begin
          st_next.load = by_band(b_max);
        end
      end
      default: st_next.load = by_band(b_max); // RL3 RL4
    endcase
    if (!live) begin
      st_next.flags = '0; // RL8
    end else if (frc) begin
      st_next.flags = forced(st_reg.force_sel); // RL11
    end else begin
      st_next.flags = flags_of(st_next.load);
    end
    st_next.evt = st_next.flags & ~st_reg.flags & st_reg.evt_sel; // RL7
    st_next.tick_cnt = tick ? 32'h0000_0000
                            : st_reg.tick_cnt + 32'h0000_0001;
    // Counters clear on any write to their offset
    if (bus_req.wr && bus_req.addr == tsm_pkg::OFS_OVL_T) begin
      st_next.ovl_time = 32'h0000_0000;
    end
    if (bus_req.wr && bus_req.addr == tsm_pkg::OFS_HOC_T) begin
      st_next.hoc_time = 32'h0000_0000;
    end
    if (tick && live && st_reg.load == tsm_pkg::LD_OVERLOAD
        && st_next.ovl_time != 32'hFFFF_FFFF) begin
      st_next.ovl_time = st_next.ovl_time + 32'h0000_0001; // RL6
    end
    if (tick && live && (st_reg.load == tsm_pkg::LD_HIGH
        || st_reg.load == tsm_pkg::LD_INRUSH)
        && st_next.hoc_time != 32'hFFFF_FFFF) begin
      st_next.hoc_time = st_next.hoc_time + 32'h0000_0001; // RL6
    end
    if (bus_req.wr) begin
      case (bus_req.addr)
        tsm_pkg::OFS_CTRL: begin
          st_next.function_operating_mode =
            tsm_pkg::tsm_mode_e'(bus_req.wdata[2:0]); // RL8
          st_next.sg_ctrl_en = bus_req.wdata[3]; // RL10
          st_next.force_en = bus_req.wdata[4];
          st_next.force_sel = tsm_pkg::tsm_force_e'(bus_req.wdata[7:5]);
          st_next.wr_group = bus_req.wdata[10:8];
        end
        tsm_pkg::OFS_POWER:
          st_next.plate[st_reg.wr_group].power = clamp_set(bus_req.wdata);
        tsm_pkg::OFS_HV_V:
          st_next.plate[st_reg.wr_group].hv_volt = clamp_set(bus_req.wdata);
        tsm_pkg::OFS_LV_V:
          st_next.plate[st_reg.wr_group].lv_volt = clamp_set(bus_req.wdata);
        tsm_pkg::OFS_ZK: begin
          if (bus_req.wdata == 32'h0000_0000) begin
            st_next.short_circuit_impedance_pct = 12'h001;
          end else if (bus_req.wdata > 32'(tsm_pkg::MAX_ZK)) begin
            st_next.short_circuit_impedance_pct = tsm_pkg::MAX_ZK;
          end else begin
            st_next.short_circuit_impedance_pct = bus_req.wdata[11:0];
          end
        end
        tsm_pkg::OFS_FREQ: begin
          if (bus_req.wdata < 32'(tsm_pkg::MIN_FREQ)) begin
            st_next.freq = tsm_pkg::MIN_FREQ;
          end else if (bus_req.wdata > 32'(tsm_pkg::MAX_FREQ)) begin
            st_next.freq = tsm_pkg::MAX_FREQ;
          end else begin
            st_next.freq = bus_req.wdata[6:0];
          end
        end
        tsm_pkg::OFS_EVSEL: st_next.evt_sel = bus_req.wdata[5:0];
        tsm_pkg::OFS_ISTAT:
          st_next.int_stat = st_reg.int_stat & ~bus_req.wdata[5:0];
        tsm_pkg::OFS_IMASK: st_next.int_mask = bus_req.wdata[5:0];
        default: st_next.int_mask = st_reg.int_mask;
      endcase
    end
    // A new event wins over a clear in the same cycle
    st_next.int_stat = st_next.int_stat | st_reg.evt;
    st_next.rdata = 32'h0000_0000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        tsm_pkg::OFS_CTRL:
          st_next.rdata = {21'h00_0000, st_reg.wr_group, st_reg.force_sel,
                           st_reg.force_en, st_reg.sg_ctrl_en,
                           st_reg.function_operating_mode};
        tsm_pkg::OFS_STATUS:
          st_next.rdata = {20'h0_0000, st_reg.grp_act, eff,
                           st_reg.flags}; // RL9
        tsm_pkg::OFS_POWER:
          st_next.rdata = {19'h0_0000, st_reg.plate[st_reg.wr_group].power};
        tsm_pkg::OFS_HV_V:
          st_next.rdata = {19'h0_0000,
                           st_reg.plate[st_reg.wr_group].hv_volt};
        tsm_pkg::OFS_LV_V:
          st_next.rdata = {19'h0_0000,
                           st_reg.plate[st_reg.wr_group].lv_volt};
        tsm_pkg::OFS_ZK:
          st_next.rdata = {20'h0_0000, st_reg.short_circuit_impedance_pct};
        tsm_pkg::OFS_FREQ:   st_next.rdata = {25'h000_0000, st_reg.freq};
        tsm_pkg::OFS_EVSEL:  st_next.rdata = {26'h000_0000, st_reg.evt_sel};
        tsm_pkg::OFS_ISTAT:  st_next.rdata = {26'h000_0000, st_reg.int_stat};
        tsm_pkg::OFS_IMASK:  st_next.rdata = {26'h000_0000, st_reg.int_mask};
        tsm_pkg::OFS_OVL_T:  st_next.rdata = st_reg.ovl_time;
        tsm_pkg::OFS_HOC_T:  st_next.rdata = st_reg.hoc_time;
        tsm_pkg::OFS_INOM_H: st_next.rdata = st_reg.inom_hv;
        tsm_pkg::OFS_INOM_L: st_next.rdata = st_reg.inom_lv;
        tsm_pkg::OFS_ISC_H:  st_next.rdata = st_reg.isc_hv;
        tsm_pkg::OFS_LSC:    st_next.rdata = st_reg.lsc;
        default:             st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= rst_state();
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data                 = st_reg.rdata;
  assign status                  = st_reg.flags;
  assign event_pulse             = st_reg.evt;
  assign function_effective_mode = eff;
  assign irq                     = |(st_reg.int_stat & st_reg.int_mask);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  noload_delay_a: assert property ( // RL1
    st_reg.load == tsm_pkg::LD_LOW_WAIT && b_max == 2'h0
    && st_reg.low_cnt < 32'(NOLOAD_CYCLES - 1)
    |=> st_reg.load == tsm_pkg::LD_LOW_WAIT)
    else $error("no-load entered before the delay ran out");
  inrush_entry_a: assert property ( // RL2
    st_reg.load == tsm_pkg::LD_NOLOAD && b_max == 2'h3 && live && !frc
    |=> st_reg.load == tsm_pkg::LD_INRUSH
        && status.hv_inrush && status.lv_inrush)
    else $error("inrush not raised on both sides");
  normal_band_a: assert property ( // RL3
    live && !frc && b_max == 2'h1 && st_reg.load != tsm_pkg::LD_INRUSH
    |=> status.load_normal)
    else $error("normal load not shown in the normal band");
  over_band_a: assert property ( // RL4
    live && !frc && b_max == 2'h2 ##1 live && !frc
    |-> status.overloading)
    else $error("overloading not shown in the overload band");
  ovl_count_a: assert property ( // RL6
    tick && live && st_reg.load == tsm_pkg::LD_OVERLOAD
    && st_reg.ovl_time < 32'h0000_FFFF && !bus_req.wr
    |=> st_reg.ovl_time == $past(st_reg.ovl_time) + 32'h0000_0001)
    else $error("overload time did not advance");
  event_sel_a: assert property ( // RL7
    event_pulse != 6'h00
    |-> (event_pulse & ~$past(st_reg.evt_sel)) == 6'h00
        && (event_pulse & ~status) == 6'h00)
    else $error("event issued without selection");
  mode_quiet_a: assert property ( // RL8
    !live ##1 !live |-> status == '0)
    else $error("outputs active in a blocked or off mode");
  eff_mode_a: assert property ( // RL9
    bus_req.wr && bus_req.addr == tsm_pkg::OFS_CTRL
    && bus_req.wdata[2:0] <= 3'h4
    |=> function_effective_mode == $past(bus_req.wdata[2:0]))
    else $error("effective mode differs from set mode");
  group_follow_a: assert property ( // RL10
    st_reg.sg_ctrl_en && !bus_req.wr
    |=> st_reg.grp_act == $past(setting_group))
    else $error("setting group not followed");
  force_gate_a: assert property ( // RL11
    live && st_reg.force_en
    && st_reg.force_sel == tsm_pkg::FORCE_OVERLOAD
    |=> status == tsm_pkg::tsm_flags_s'(6'h10))
    else $error("forced state not applied");
endmodule : tsm_monitor
`default_nettype wire

//--- sim/tsm_cur_src.sv
// Purpose: Model of the phase current measurement channels
// Assumes: Set values in 0.1 A steps, one cycle of conversion lag
// Notes:   Outputs read zero while reset is held
`timescale 1ns/1ps
`default_nettype none
module tsm_cur_src (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [15:0] hv_set,
  input  wire logic [15:0] lv_set,
  output var  logic [15:0] hv_current,
  output var  logic [15:0] lv_current
);
  always_ff @(posedge core_clk) begin
    hv_current <= rst ? 16'h0000 : hv_set;
    lv_current <= rst ? 16'h0000 : lv_set;
  end
endmodule : tsm_cur_src
`default_nettype wire

//--- sim/tsm_monitor_tb.sv
// Purpose: Self-checking bench of the transformer load state monitor
// Assumes: Short no-load wait and ms tick through parameters
// Notes:   Random loads keep clear of band limits
`timescale 1ns/1ps
`default_nettype none
module tsm_monitor_tb;
  localparam int NLC = 20;
  logic                  core_clk, rst, irq;
  tsm_pkg::tsm_bus_req_s bus_req;
  logic [31:0]           rd_data, v;
  logic [15:0]           hv_set, lv_set, hv_current, lv_current;
  logic [2:0]            setting_group;
  tsm_pkg::tsm_flags_s   status;
  logic [5:0]            event_pulse;
  tsm_pkg::tsm_mode_e    function_effective_mode;
  int                    n_errors, total_checks, seed, ev_cnt[6], e4, e5, w;
  real                   inom;
  real                   lo[3] = '{0.3, 1.05, 1.4};
  real                   wd[3] = '{0.6, 0.2, 1.5};
  logic [7:0]            ofs[12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
    8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h40};
  logic [11:0]           dflt[12] = '{12'h000, 12'h008, 12'h00A, 12'h44C,
    12'h44C, 12'h12C, 12'h032, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};

  tsm_cur_src src (.core_clk(core_clk), .rst(rst), .hv_set(hv_set),
    .lv_set(lv_set), .hv_current(hv_current), .lv_current(lv_current));
  tsm_monitor #(.NOLOAD_CYCLES(NLC), .TICK_CYCLES(10)) dut (
    .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .hv_current(hv_current), .lv_current(lv_current),
    .setting_group(setting_group), .status(status),
    .event_pulse(event_pulse),
    .function_effective_mode(function_effective_mode), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    for (int i = 0; i < 6; i++) if (event_pulse[i] === 1'b1) ev_cnt[i]++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1 v = rd_data;
  endtask : rd
  function automatic logic [5:0] band(input real p);
    return p < 1.0 ? 6'h08 : (p <= 1.3 ? 6'h10 : 6'h20);
  endfunction : band
  function automatic logic near(input logic [31:0] s, input real e,
                                input real tol);
    return real'(s) >= e * (1.0 - tol) && real'(s) <= e * (1.0 + tol);
  endfunction : near
  function automatic real pick();
    int k;
    k = $random(seed);
    return lo[k[1:0] % 3] + wd[k[1:0] % 3] * real'(k[11:2]) / 1024.0;
  endfunction : pick
  task automatic load(input real ph, input real pl);
    @(posedge core_clk);
    hv_set <= 16'(int'(ph * inom));
    lv_set <= 16'(int'(pl * inom));
    cyc(6);
  endtask : load
  task automatic final_report;
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    real ph, pl, ia;
    seed = 32'h82015a86;
    rst = 1'b1;
    bus_req = '0;
    setting_group = 3'h0;
    hv_set = 16'h001E;
    lv_set = 16'h001E;
    inom = 1.0e5 / (1.7320508 * 1100.0);
    cyc(12);
    rst <= 1'b0;
    cyc(8);
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk(v, 32'(dflt[i]));
    end
    wr(tsm_pkg::OFS_POWER, 32'h0000_0000);
    rd(tsm_pkg::OFS_POWER);
    chk(v, 32'h0000_0001);
    wr(tsm_pkg::OFS_POWER, 32'h0000_1388);
    wr(tsm_pkg::OFS_HV_V, 32'h0000_0064);
    wr(tsm_pkg::OFS_FREQ, 32'h0000_000A);
    cyc(4);
    ia = 5.0e8 / (1.7320508 * 1.0e4);
    rd(tsm_pkg::OFS_INOM_H);
    chk(32'(near(v, ia, 0.001)), 32'h0000_0001);
    rd(tsm_pkg::OFS_INOM_L);
    chk(32'(near(v, ia / 11.0, 0.001)), 32'h0000_0001);
    rd(tsm_pkg::OFS_ISC_H);
    chk(32'(near(v, ia * 100.0 / 3.0, 0.001)), 32'h0000_0001);
    ia = 3.0e12 / (5.0e8 * 62.831853);
    rd(tsm_pkg::OFS_LSC);
    chk(32'(near(v, ia, 0.02)), 32'h0000_0001);
    wr(tsm_pkg::OFS_POWER, 32'h0000_000A);
    wr(tsm_pkg::OFS_HV_V, 32'h0000_044C);
    cyc(4);
    for (int i = 0; i < 40; i++) begin
      ph = pick();
      pl = pick();
      load(ph, pl);
      chk({26'h0, status}, band(ph) > band(pl) ? band(ph) : band(pl));
    end
    load(0.6, 0.6);
    for (int m = 0; m < 5; m++) begin
      wr(tsm_pkg::OFS_CTRL, 32'(m));
      cyc(4);
      chk(32'(function_effective_mode), 32'(m));
      chk({26'h0, status}, (m == 1 || m > 2) ? 6'h00 : 6'h08);
    end
    for (int k = 0; k < 7; k++) begin
      wr(tsm_pkg::OFS_CTRL, 32'(k * 32 + 16));
      cyc(4);
      chk({26'h0, status}, k == 0 ? 6'h08 : 6'(1 << (k - 1)));
    end
    wr(tsm_pkg::OFS_CTRL, 32'h0000_00A0);
    cyc(4);
    chk({26'h0, status}, 6'h08);
    wr(tsm_pkg::OFS_CTRL, 32'h0000_0100);
    wr(tsm_pkg::OFS_POWER, 32'h0000_0014);
    load(1.14, 0.3);
    chk({26'h0, status}, 6'h10);
    @(posedge core_clk) setting_group <= 3'h1;
    wr(tsm_pkg::OFS_CTRL, 32'h0000_0108);
    cyc(4);
    chk({26'h0, status}, 6'h08);
    @(posedge core_clk) setting_group <= 3'h0;
    cyc(4);
    chk({26'h0, status}, 6'h10);
    wr(tsm_pkg::OFS_CTRL, 32'h0000_0000);
    wr(tsm_pkg::OFS_LV_V, 32'h0000_0898);
    load(0.6, 0.6);
    chk({26'h0, status}, 6'h10);
    wr(tsm_pkg::OFS_LV_V, 32'h0000_044C);
    wr(tsm_pkg::OFS_EVSEL, 32'h0000_0010);
    wr(tsm_pkg::OFS_IMASK, 32'h0000_0010);
    cyc(4);
    e4 = ev_cnt[4];
    e5 = ev_cnt[5];
    load(1.2, 0.6);
    load(2.0, 0.6);
    chk(32'(ev_cnt[4] - e4), 32'h0000_0001);
    chk(32'(ev_cnt[5] - e5), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0001);
    rd(tsm_pkg::OFS_ISTAT);
    chk(v, 32'h0000_0010);
    wr(tsm_pkg::OFS_IMASK, 32'h0000_0000);
    cyc(1);
    chk(32'(irq), 32'h0000_0000);
    wr(tsm_pkg::OFS_IMASK, 32'h0000_0010);
    wr(tsm_pkg::OFS_ISTAT, 32'h0000_0010);
    cyc(1);
    chk(32'(irq), 32'h0000_0000);
    load(1.2, 0.6);
    wr(tsm_pkg::OFS_OVL_T, 32'h0000_0000);
    wr(tsm_pkg::OFS_HOC_T, 32'h0000_0000);
    cyc(200);
    rd(tsm_pkg::OFS_OVL_T);
    chk(32'(v >= 19 && v <= 22), 32'h0000_0001);
    rd(tsm_pkg::OFS_HOC_T);
    chk(v, 32'h0000_0000);
    load(0.1, 0.1);
    chk({26'h0, status}, 6'h08);
    for (w = 0; w < NLC + 20 && status !== 6'h01; w++) cyc(1);
    chk({26'h0, status}, 6'h01);
    if (status === 6'h01) begin
      chk(32'(w + 6 > NLC), 32'h0000_0001);
      load(2.0, 2.0);
      chk({26'h0, status}, 6'h06);
    end
    final_report();
  end
endmodule : tsm_monitor_tb
`default_nettype wire
